// ### rtl/scsi_command_admission.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviours
// Behaviour
// - 25h reports capacity; PMI honoured, relative addressing refused, allowed under protect.
// - 37h reports defect lists in either form; allowed under protect, not before spinup.
// - long read returns one whole sector; allowed under protect, not before spinup.
// - 07h reassigns blocks; refused before spinup and under protect.
// - 1Ch returns last diagnostic outcome; allowed under protect, not before spinup.
// - 17h releases unit or third party, not extent; always accepted.
// - 03h returns extended sense only, pointers unused; always accepted.
// - 16h reserves unit or third party, extent rejected; always accepted.
// - 01h recalibrates then seeks block zero; allowed under protect, not before spinup.
// - 0Bh and 2Bh seek; good status only after seek done; not before spinup.
// - 1Dh self-test or translate; failed self-test ends with check condition.
// - 1Bh starts or stops the spindle; always accepted.
// - 35h flushes cached blocks; refused before spinup and under protect.
// - 00h tests spindle speed; good when at speed; accepted any time.
// - 2Fh verifies media; relative addressing rejected; refused before spinup or protect.
// - 0Ah and 2Ah write; refused before spinup and under protect.
// - 2Eh writes then verifies; refused before spinup and under protect.
// - 3Bh buffer write; refused before spinup or protect; host should reserve first.
// - 3Fh long write of one sector; refused before spinup and under protect.
// - 41h writes one block repeatedly; refused before spinup and under protect.
// - mode select and sense allowed before spinup only without saved pages.
// - mode select control bit 7 sets or clears write protect.
module scsi_command_admission
   import cmd_admit_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic cdb_valid,
   input wire cdb_s cdb,
   input wire logic spindle_at_speed,
   input wire logic op_done,
   input wire logic op_fail,
   output logic busy,
   output dispatch_s dispatch,
   output logic dispatch_valid,
   output logic pmi_enable,
   output logic [1:0] page_control,
   output logic status_valid,
   output logic [7:0] status,
   output sense_s sense,
   output logic write_protect,
   output logic last_diag_fail
);

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_RUN = 3'b010,
      ST_DONE = 3'b100
   } state_e;

   state_e state;
   decode_s dec;
   dispatch_s held;
   logic refuse_spin;
   logic refuse_wp;
   logic accept;
   logic take;

   opcode_decode u_decode (
      .cdb(cdb),
      .dec(dec)
   );

   assign take = cdb_valid & (state == ST_IDLE);
   assign refuse_spin = ~spindle_at_speed & ~dec.spin_ok;
   assign refuse_wp = write_protect & ~dec.wp_ok;
   assign accept = dec.known & ~dec.field_bad & ~refuse_spin & ~refuse_wp;

   // sequencing: idle, engine running, status returned
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= ST_IDLE;
      end else begin
         case (state)
            ST_IDLE: begin
               if (take && accept && dec.action != ACT_TEST_READY) begin
                  state <= ST_RUN;
               end else if (take) begin
                  state <= ST_DONE;
               end
            end
            ST_RUN: begin
               if (op_done) begin
                  state <= ST_DONE;
               end
            end
            ST_DONE: state <= ST_IDLE;
            default: state <= ST_IDLE;
         endcase
      end
   end

   // busy flag
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         busy <= 1'b0;
      end else begin
         busy <= (state == ST_IDLE) ? take : (state == ST_RUN);
      end
   end

   // command held for the engines
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         held <= '0;
         dispatch <= '0;
         dispatch_valid <= 1'b0;
         pmi_enable <= 1'b0;
         page_control <= 2'h0;
      end else begin
         dispatch_valid <= 1'b0;
         if (take && accept && dec.action != ACT_TEST_READY) begin
            held <= '{action: dec.action, byte1: cdb.byte1, byte2: cdb.byte2};
            dispatch <= '{action: dec.action, byte1: cdb.byte1, byte2: cdb.byte2};
            dispatch_valid <= 1'b1;
            pmi_enable <= (dec.action == ACT_CAPACITY) & cdb.byte2[PMI_BIT];
            page_control <= cdb.byte2[PAGE_CTRL_HI:PAGE_CTRL_LO];
         end
      end
   end

   // write protect mode from mode select control byte
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         write_protect <= 1'b0;
      end else if (take && accept && dec.action == ACT_MODE_SELECT) begin
         write_protect <= cdb.control[WP_CTRL_BIT];
      end
   end

   // result of the most recent diagnostic
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         last_diag_fail <= 1'b0;
      end else if (state == ST_RUN && op_done && held.action == ACT_DIAG) begin
         last_diag_fail <= op_fail;
      end
   end

   // status and sense entry
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         status_valid <= 1'b0;
         status <= STATUS_GOOD;
         sense <= '{key: KEY_NONE, code: ASC_NONE};
      end else begin
         status_valid <= 1'b0;
         if (take) begin
            if (!dec.known) begin
               status_valid <= 1'b1;
               status <= STATUS_CHECK;
               sense <= '{key: KEY_ILLEGAL, code: ASC_BAD_OPCODE};
            end else if (dec.field_bad) begin
               status_valid <= 1'b1;
               status <= STATUS_CHECK;
               sense <= '{key: KEY_ILLEGAL, code: ASC_BAD_FIELD};
            end else if (refuse_spin) begin
               status_valid <= 1'b1;
               status <= STATUS_CHECK;
               sense <= '{key: KEY_NOT_READY, code: ASC_NOT_READY};
            end else if (refuse_wp) begin
               status_valid <= 1'b1;
               status <= STATUS_CHECK;
               sense <= '{key: KEY_PROTECT, code: ASC_PROTECTED};
            end else if (dec.action == ACT_TEST_READY) begin
               // accepted at any time, but good only once the spindle is at speed
               status_valid <= 1'b1;
               if (spindle_at_speed) begin
                  status <= STATUS_GOOD;
                  sense <= '{key: KEY_NONE, code: ASC_NONE};
               end else begin
                  status <= STATUS_CHECK;
                  sense <= '{key: KEY_NOT_READY, code: ASC_NOT_READY};
               end
            end else if (dec.action == ACT_SENSE) begin
               sense <= sense;
            end
         end else if (state == ST_RUN && op_done) begin
            status_valid <= 1'b1;
            if (op_fail) begin
               status <= STATUS_CHECK;
               sense <= '{key: KEY_HW_ERROR, code: ASC_DIAG_FAIL};
            end else begin
               status <= STATUS_GOOD;
               if (held.action != ACT_SENSE) begin
                  sense <= '{key: KEY_NONE, code: ASC_NONE};
               end
            end
         end
      end
   end

endmodule
`default_nettype wire

// ### rtl/cmd_admit_pkg.sv
`default_nettype none
package cmd_admit_pkg;

   // operation codes
   localparam logic [7:0] OP_TEST_READY = 8'h00;
   localparam logic [7:0] OP_REZERO = 8'h01;
   localparam logic [7:0] OP_SENSE = 8'h03;
   localparam logic [7:0] OP_REASSIGN = 8'h07;
   localparam logic [7:0] OP_WRITE6 = 8'h0A;
   localparam logic [7:0] OP_SEEK6 = 8'h0B;
   localparam logic [7:0] OP_MSEL6 = 8'h15;
   localparam logic [7:0] OP_RESERVE = 8'h16;
   localparam logic [7:0] OP_RELEASE = 8'h17;
   localparam logic [7:0] OP_MSENSE6 = 8'h1A;
   localparam logic [7:0] OP_START_STOP = 8'h1B;
   localparam logic [7:0] OP_DIAG_RESULT = 8'h1C;
   localparam logic [7:0] OP_DIAG = 8'h1D;
   localparam logic [7:0] OP_CAPACITY = 8'h25;
   localparam logic [7:0] OP_WRITE10 = 8'h2A;
   localparam logic [7:0] OP_SEEK10 = 8'h2B;
   localparam logic [7:0] OP_WRITE_VERIFY = 8'h2E;
   localparam logic [7:0] OP_VERIFY = 8'h2F;
   localparam logic [7:0] OP_SYNC_CACHE = 8'h35;
   localparam logic [7:0] OP_DEFECT_DATA = 8'h37;
   localparam logic [7:0] OP_WRITE_BUFFER = 8'h3B;
   localparam logic [7:0] OP_READ_LONG = 8'h3E;
   localparam logic [7:0] OP_WRITE_LONG = 8'h3F;
   localparam logic [7:0] OP_WRITE_SAME = 8'h41;
   localparam logic [7:0] OP_MSEL10 = 8'h55;
   localparam logic [7:0] OP_MSENSE10 = 8'h5A;

   // field positions
   localparam int WP_CTRL_BIT = 7;
   localparam int PAGE_CTRL_HI = 7;
   localparam int PAGE_CTRL_LO = 6;
   localparam int SAVE_PAGE_BIT = 0;
   localparam int RELADR_BIT = 0;
   localparam int PMI_BIT = 0;
   localparam logic [1:0] PAGE_CTRL_SAVED = 2'h3;

   // status codes
   localparam logic [7:0] STATUS_GOOD = 8'h00;
   localparam logic [7:0] STATUS_CHECK = 8'h02;

   // sense keys and codes
   localparam logic [3:0] KEY_NONE = 4'h0;
   localparam logic [3:0] KEY_NOT_READY = 4'h2;
   localparam logic [3:0] KEY_HW_ERROR = 4'h4;
   localparam logic [3:0] KEY_ILLEGAL = 4'h5;
   localparam logic [3:0] KEY_PROTECT = 4'h7;
   localparam logic [7:0] ASC_NONE = 8'h00;
   localparam logic [7:0] ASC_NOT_READY = 8'h04;
   localparam logic [7:0] ASC_BAD_OPCODE = 8'h20;
   localparam logic [7:0] ASC_BAD_FIELD = 8'h24;
   localparam logic [7:0] ASC_PROTECTED = 8'h27;
   localparam logic [7:0] ASC_DIAG_FAIL = 8'h40;

   typedef enum logic [4:0] {
      ACT_NONE = 5'h00, ACT_CAPACITY, ACT_DEFECT, ACT_READ_LONG, ACT_REASSIGN,
      ACT_DIAG_RESULT, ACT_RELEASE, ACT_SENSE, ACT_RESERVE, ACT_REZERO, ACT_SEEK,
      ACT_DIAG, ACT_START_STOP, ACT_SYNC, ACT_TEST_READY, ACT_VERIFY, ACT_WRITE,
      ACT_WRITE_VERIFY, ACT_WRITE_BUFFER, ACT_WRITE_LONG, ACT_WRITE_SAME,
      ACT_MODE_SELECT, ACT_MODE_SENSE
   } action_e;

   // command as received
   typedef struct packed {
      logic [7:0] opcode;
      logic [7:0] byte1;
      logic [7:0] byte2;
      logic [7:0] control;
   } cdb_s;

   // decode outcome
   typedef struct packed {
      action_e action;
      logic known;
      logic spin_ok;
      logic wp_ok;
      logic field_bad;
   } decode_s;

   // command handed to the engines
   typedef struct packed {
      action_e action;
      logic [7:0] byte1;
      logic [7:0] byte2;
   } dispatch_s;

   typedef struct packed {
      logic [3:0] key;
      logic [7:0] code;
   } sense_s;

endpackage
`default_nettype wire

// ### rtl/opcode_decode.sv
`timescale 1ns/1ps
`default_nettype none
module opcode_decode
   import cmd_admit_pkg::*;
(
   input wire cdb_s cdb,
   output decode_s dec
);

   logic saved_pages;
   logic reladr;

   assign saved_pages = (cdb.byte2[PAGE_CTRL_HI:PAGE_CTRL_LO] == PAGE_CTRL_SAVED) | cdb.byte1[SAVE_PAGE_BIT];
   assign reladr = cdb.byte1[RELADR_BIT];

   // table lookup: action, before-spinup and write-protect permission
   always_comb begin
      dec = '0;
      dec.known = 1'b1;
      case (cdb.opcode)
         OP_CAPACITY: begin
            dec.action = ACT_CAPACITY;
            dec.wp_ok = 1'b1;
            dec.field_bad = reladr;
         end
         OP_DEFECT_DATA: begin
            dec.action = ACT_DEFECT;
            dec.wp_ok = 1'b1;
         end
         OP_READ_LONG: begin
            dec.action = ACT_READ_LONG;
            dec.wp_ok = 1'b1;
         end
         OP_REASSIGN: dec.action = ACT_REASSIGN;
         OP_DIAG_RESULT: begin
            dec.action = ACT_DIAG_RESULT;
            dec.wp_ok = 1'b1;
         end
         OP_RELEASE: begin
            dec.action = ACT_RELEASE;
            dec.spin_ok = 1'b1;
            dec.wp_ok = 1'b1;
            dec.field_bad = cdb.byte1[RELADR_BIT];
         end
         OP_SENSE: begin
            dec.action = ACT_SENSE;
            dec.spin_ok = 1'b1;
            dec.wp_ok = 1'b1;
         end
         OP_RESERVE: begin
            dec.action = ACT_RESERVE;
            dec.spin_ok = 1'b1;
            dec.wp_ok = 1'b1;
            dec.field_bad = cdb.byte1[RELADR_BIT];
         end
         OP_REZERO: begin
            dec.action = ACT_REZERO;
            dec.wp_ok = 1'b1;
         end
         OP_SEEK6, OP_SEEK10: begin
            dec.action = ACT_SEEK;
            dec.wp_ok = 1'b1;
         end
         OP_DIAG: begin
            dec.action = ACT_DIAG;
            dec.wp_ok = 1'b1;
         end
         OP_START_STOP: begin
            dec.action = ACT_START_STOP;
            dec.spin_ok = 1'b1;
            dec.wp_ok = 1'b1;
         end
         OP_SYNC_CACHE: dec.action = ACT_SYNC;
         OP_TEST_READY: begin
            dec.action = ACT_TEST_READY;
            dec.spin_ok = 1'b1;
            dec.wp_ok = 1'b1;
         end
         OP_VERIFY: begin
            dec.action = ACT_VERIFY;
            dec.field_bad = reladr;
         end
         OP_WRITE6, OP_WRITE10: dec.action = ACT_WRITE;
         OP_WRITE_VERIFY: dec.action = ACT_WRITE_VERIFY;
         OP_WRITE_BUFFER: dec.action = ACT_WRITE_BUFFER;
         OP_WRITE_LONG: dec.action = ACT_WRITE_LONG;
         OP_WRITE_SAME: dec.action = ACT_WRITE_SAME;
         OP_MSEL6, OP_MSEL10: begin
            dec.action = ACT_MODE_SELECT;
            dec.spin_ok = ~saved_pages;
            dec.wp_ok = 1'b1;
         end
         OP_MSENSE6, OP_MSENSE10: begin
            dec.action = ACT_MODE_SENSE;
            dec.spin_ok = ~saved_pages;
            dec.wp_ok = 1'b1;
         end
         default: dec.known = 1'b0;
      endcase
   end

endmodule
`default_nettype wire

// ### verif/cmd_admit_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module cmd_admit_monitor
   import cmd_admit_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic spindle_at_speed,
   input wire logic op_done,
   input wire logic op_fail,
   input wire logic busy,
   input wire dispatch_s dispatch,
   input wire logic dispatch_valid,
   input wire logic status_valid,
   input wire logic [7:0] status,
   input wire logic write_protect
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   // engine completion followed by the status pulse
   sequence s_end;
      op_done ##1 status_valid;
   endsequence
   a_dispatch_pulse: assert property (dispatch_valid |-> busy ##1 !dispatch_valid)
      else $error("dispatch pulse malformed");
   a_end_status: assert property (busy && op_done && !status_valid |-> s_end)
      else $error("no status after engine done");
   a_status_idle: assert property (status_valid |-> busy ##1 (!status_valid && !busy))
      else $error("status pulse malformed");
   a_no_early: assert property (busy && !op_done |=> !status_valid)
      else $error("status before engine done");
   a_fail_check: assert property (busy && op_done && op_fail |=> status == STATUS_CHECK)
      else $error("failed operation not check");
   a_good_done: assert property (busy && op_done && !op_fail |=> status == STATUS_GOOD)
      else $error("good operation not good");
   a_spin_gate: assert property (dispatch_valid && !$past(spindle_at_speed) |-> dispatch.action inside
      {ACT_RELEASE, ACT_SENSE, ACT_RESERVE, ACT_START_STOP, ACT_MODE_SELECT, ACT_MODE_SENSE})
      else $error("command run before spinup");
   a_wp_gate: assert property (dispatch_valid && $past(write_protect) |-> !(dispatch.action inside
      {ACT_REASSIGN, ACT_SYNC, ACT_VERIFY, ACT_WRITE, ACT_WRITE_VERIFY, ACT_WRITE_BUFFER, ACT_WRITE_LONG,
      ACT_WRITE_SAME}))
      else $error("command run under protect");
endmodule
`default_nettype wire

// ### verif/op_engine_model.sv
`timescale 1ns/1ps
`default_nettype none
module op_engine_model (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic dispatch_valid,
   input wire logic [7:0] delay,
   input wire logic fail,
   output logic op_done,
   output logic op_fail
);
   logic [7:0] count;
   logic running;
   // counts down after a dispatch, then reports done once; fail flag toggles when meaningless
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         count <= 8'h00;
         running <= 1'b0;
         op_done <= 1'b0;
         op_fail <= 1'b0;
      end else begin
         op_done <= 1'b0;
         op_fail <= ~op_fail;
         if (dispatch_valid) begin
            running <= 1'b1;
            count <= delay;
         end else if (running && count == 8'h00) begin
            running <= 1'b0;
            op_done <= 1'b1;
            op_fail <= fail;
         end else if (running) begin
            count <= count - 8'h01;
         end
      end
   end
endmodule
`default_nettype wire

// ### verif/tb_scsi_command_admission.sv
`timescale 1ns/1ps
`default_nettype none
module tb_scsi_command_admission;
   import cmd_admit_pkg::*;
   logic sys_clk = 1'b0, reset_n = 1'b0, cdb_valid = 1'b0, spindle_at_speed = 1'b0, fail = 1'b0;
   logic op_done, op_fail, busy, dispatch_valid, pmi_enable, status_valid, write_protect, last_diag_fail;
   logic [1:0] page_control;
   logic [7:0] status, delay = 8'h00;
   cdb_s cdb = '0;
   dispatch_s dispatch;
   sense_s sense, got_sense;
   logic [7:0] got_st;
   logic got_disp, got_pmi;
   int lat, miscompares = 0, tests_run = 0;
   // first eight allowed under protect, last nine refused
   logic [7:0] ops [17] = '{8'h25, 8'h37, 8'h3E, 8'h1C, 8'h01, 8'h0B, 8'h2B, 8'h1D,
      8'h07, 8'h35, 8'h2F, 8'h0A, 8'h2A, 8'h2E, 8'h3B, 8'h3F, 8'h41};
   logic [7:0] early [6] = '{8'h17, 8'h03, 8'h16, 8'h1B, 8'h15, 8'h1A};
   logic [7:0] fld [4] = '{8'h25, 8'h2F, 8'h16, 8'h17};
   scsi_command_admission u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .cdb_valid(cdb_valid), .cdb(cdb),
      .spindle_at_speed(spindle_at_speed), .op_done(op_done), .op_fail(op_fail), .busy(busy),
      .dispatch(dispatch), .dispatch_valid(dispatch_valid), .pmi_enable(pmi_enable),
      .page_control(page_control), .status_valid(status_valid), .status(status), .sense(sense),
      .write_protect(write_protect), .last_diag_fail(last_diag_fail));
   op_engine_model u_eng (.sys_clk(sys_clk), .reset_n(reset_n), .dispatch_valid(dispatch_valid),
      .delay(delay), .fail(fail), .op_done(op_done), .op_fail(op_fail));
   // clock of 100 ns period
   initial begin
      forever #50 sys_clk = ~sys_clk;
   end
   // one command: present, wait for status, then leave two idle cycles
   task automatic run(input logic [7:0] op, b1, b2, ct);
      got_disp = 1'b0;
      lat = 0;
      @(posedge sys_clk);
      cdb_valid <= 1'b1;
      cdb <= '{op, b1, b2, ct};
      for (int n = 0; n < 300; n++) begin
         @(posedge sys_clk);
         cdb_valid <= 1'b0;
         #1;
         if (dispatch_valid === 1'b1) begin
            got_disp = 1'b1;
            got_pmi = pmi_enable;
         end
         if (status_valid === 1'b1) break;
         lat++;
      end
      got_st = status;
      got_sense = sense;
      repeat (2) @(posedge sys_clk);
   endtask
   task automatic chk_resp(input logic [3:0] k, input logic [7:0] c, input logic d);
      tests_run++;
      if (got_disp !== d || got_st !== (k == KEY_NONE ? STATUS_GOOD : STATUS_CHECK) ||
         (k != KEY_NONE && got_sense !== {k, c})) begin
         miscompares++;
         $display("[ERR] %0t op %h st %h sense %h disp %b", $time, cdb.opcode, got_st, got_sense, got_disp);
      end
   endtask
   task automatic chk_bit(input logic g, e);
      tests_run++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] %0t flag mismatch", $time);
      end
   endtask
   task automatic t_before_spin();
      foreach (ops[i]) begin
         run(ops[i], 8'h00, 8'h00, 8'h00);
         chk_resp(KEY_NOT_READY, ASC_NOT_READY, 1'b0);
      end
      run(8'h00, 8'h00, 8'h00, 8'h00);
      chk_resp(KEY_NOT_READY, ASC_NOT_READY, 1'b0);
      foreach (early[i]) begin
         run(early[i], 8'h00, 8'h00, 8'h00);
         chk_resp(KEY_NONE, ASC_NONE, 1'b1);
      end
      run(8'h1A, 8'h00, 8'hC0, 8'h00);
      chk_resp(KEY_NOT_READY, ASC_NOT_READY, 1'b0);
      run(8'h15, 8'h01, 8'h00, 8'h00);
      chk_resp(KEY_NOT_READY, ASC_NOT_READY, 1'b0);
   endtask
   task automatic t_fields();
      run(8'hFF, 8'h00, 8'h00, 8'h00);
      chk_resp(KEY_ILLEGAL, ASC_BAD_OPCODE, 1'b0);
      foreach (fld[i]) begin
         run(fld[i], 8'h01, 8'h00, 8'h00);
         chk_resp(KEY_ILLEGAL, ASC_BAD_FIELD, 1'b0);
      end
   endtask
   task automatic t_spun();
      spindle_at_speed <= 1'b1;
      run(8'h00, 8'h00, 8'h00, 8'h00);
      chk_resp(KEY_NONE, ASC_NONE, 1'b0);
      run(8'h16, 8'h00, 8'h00, 8'h00);
      foreach (ops[i]) begin
         run(ops[i], 8'h00, 8'h00, 8'h00);
         chk_resp(KEY_NONE, ASC_NONE, 1'b1);
      end
      run(8'h25, 8'h00, 8'h01, 8'h00);
      chk_bit(got_pmi, 1'b1);
      run(8'h25, 8'h00, 8'h00, 8'h00);
      chk_bit(got_pmi, 1'b0);
      run(8'h1A, 8'h00, 8'h80, 8'h00);
      chk_bit(page_control == 2'h2, 1'b1);
      delay <= 8'h14;
      run(8'h2B, 8'h00, 8'h00, 8'h00);
      chk_bit(lat >= 20, 1'b1);
      delay <= 8'h00;
   endtask
   task automatic t_protect();
      run(8'h15, 8'h00, 8'h00, 8'h80);
      chk_bit(write_protect, 1'b1);
      foreach (ops[i]) begin
         run(ops[i], 8'h00, 8'h00, 8'h00);
         if (i < 8) chk_resp(KEY_NONE, ASC_NONE, 1'b1);
         else chk_resp(KEY_PROTECT, ASC_PROTECTED, 1'b0);
      end
      spindle_at_speed <= 1'b0;
      run(8'h0A, 8'h00, 8'h00, 8'h00);
      chk_resp(KEY_NOT_READY, ASC_NOT_READY, 1'b0);
      spindle_at_speed <= 1'b1;
      run(8'h15, 8'h00, 8'h00, 8'h00);
      chk_bit(write_protect, 1'b0);
   endtask
   task automatic t_fail();
      fail <= 1'b1;
      run(8'h1D, 8'h00, 8'h00, 8'h00);
      chk_resp(KEY_HW_ERROR, ASC_DIAG_FAIL, 1'b1);
      chk_bit(last_diag_fail, 1'b1);
      fail <= 1'b0;
      run(8'h03, 8'h00, 8'h00, 8'h00);
      chk_resp(KEY_NONE, ASC_NONE, 1'b1);
      chk_bit(got_sense == {KEY_HW_ERROR, ASC_DIAG_FAIL}, 1'b1);
      run(8'h1D, 8'h00, 8'h00, 8'h00);
      chk_resp(KEY_NONE, ASC_NONE, 1'b1);
      chk_bit(last_diag_fail, 1'b0);
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (10) @(posedge sys_clk);
      reset_n <= 1'b1;
      t_before_spin();
      t_fields();
      t_spun();
      t_protect();
      t_fail();
      summarize();
   end
   // watchdog
   initial begin
      repeat (20000) @(posedge sys_clk);
      miscompares++;
      summarize();
   end
endmodule
bind scsi_command_admission cmd_admit_monitor u_mon (.sys_clk(sys_clk), .reset_n(reset_n),
   .spindle_at_speed(spindle_at_speed), .op_done(op_done), .op_fail(op_fail), .busy(busy),
   .dispatch(dispatch), .dispatch_valid(dispatch_valid), .status_valid(status_valid), .status(status),
   .write_protect(write_protect));
`default_nettype wire
